// >>> hdl/psam_pkg.sv
`default_nettype none

package psam_pkg;

  // Address and data widths
  localparam int PADDR_W = 24;
  localparam int IP_W    = 23;
  localparam int WORD_W  = 24;
  localparam int DATA_W  = 16;
  localparam int PAGE_W  = 8;
  localparam int OFS_W   = 16;
  localparam int DS_W    = 16;
  localparam int REMAP_W = 15;

  // Field positions
  localparam int PAGE_UPPER_BIT = 7;
  localparam int ADDR_UPPER_BIT = 23;
  localparam int DS_REMAP_BIT   = 15;

  // Program space map
  localparam logic [23:0] USER_FIRST = 24'h00_0000;
  localparam logic [23:0] USER_LAST  = 24'h7F_FFFF;
  localparam logic [23:0] CFG_FIRST  = 24'hF8_0000;
  localparam logic [23:0] CFG_LAST   = 24'hF8_00FF;
  localparam logic [23:0] DEVID_FIRST = 24'hFF_0000;
  localparam logic [23:0] DEVID_LAST  = 24'hFF_0003;

  // Reset values
  localparam logic [7:0]  TABLE_PAGE_RST = 8'h00;
  localparam logic [7:0]  REMAP_PAGE_RST = 8'h00;

  // Byte lanes of a 24-bit program word
  localparam logic [2:0]  STRB_LOW  = 3'h3;
  localparam logic [2:0]  STRB_HIGH = 3'h4;
  localparam logic [2:0]  STRB_NONE = 3'h0;

  typedef enum logic [1:0] {
    PSAM_SRC_FETCH,
    PSAM_SRC_TABLE,
    PSAM_SRC_REMAP
  } psam_src_e;

  typedef enum logic [1:0] {
    PSAM_REG_USER,
    PSAM_REG_CONFIG,
    PSAM_REG_DEVID,
    PSAM_REG_HOLE
  } psam_region_e;

  function automatic logic psam_in_range(input logic [23:0] addr,
                                         input logic [23:0] first,
                                         input logic [23:0] last);
    psam_in_range = (addr >= first) && (addr <= last);
  endfunction

endpackage

`default_nettype wire

// >>> hdl/psam_if.sv
`timescale 1ns/10ps
`default_nettype none

interface psam_if;
  psam_pkg::psam_src_e    src;
  logic [22:0]            ip;
  logic [7:0]             table_page;
  logic [15:0]            table_ofs;
  logic [7:0]             remap_page;
  logic [15:0]            ds_addr;
  logic [23:0]            paddr;
  psam_pkg::psam_region_e region;
  logic                   upper;

  modport requester (
    output src, ip, table_page, table_ofs, remap_page, ds_addr,
    input  paddr, region, upper
  );
  modport former (
    input  src, ip, table_page, table_ofs, remap_page, ds_addr,
    output paddr, region, upper
  );
endinterface

`default_nettype wire

// >>> hdl/psam_addr_gen.sv
`timescale 1ns/10ps
`default_nettype none

module psam_addr_gen (
  // Address sources in, program address out
  psam_if.former af
);

  logic [23:0] addr;

  always_comb begin
    case (af.src)
      psam_pkg::PSAM_SRC_FETCH: begin
        addr = {1'b0, af.ip};
      end
      psam_pkg::PSAM_SRC_TABLE: begin
        addr = {af.table_page, af.table_ofs};
      end
      psam_pkg::PSAM_SRC_REMAP: begin
        // Window of data space folded onto a page of program space
        addr = {1'b0, af.remap_page,
                af.ds_addr[psam_pkg::REMAP_W-1:0]};
      end
      default: begin
        addr = psam_pkg::USER_FIRST;
      end
    endcase
  end

  assign af.paddr = addr;
  assign af.upper = addr[psam_pkg::ADDR_UPPER_BIT];

  always_comb begin
    if (psam_pkg::psam_in_range(addr, psam_pkg::USER_FIRST,
                                psam_pkg::USER_LAST)) begin
      af.region = psam_pkg::PSAM_REG_USER;
    end else if (psam_pkg::psam_in_range(addr, psam_pkg::CFG_FIRST,
                                         psam_pkg::CFG_LAST)) begin
      af.region = psam_pkg::PSAM_REG_CONFIG;
    end else if (psam_pkg::psam_in_range(addr, psam_pkg::DEVID_FIRST,
                                         psam_pkg::DEVID_LAST)) begin
      af.region = psam_pkg::PSAM_REG_DEVID;
    end else begin
      af.region = psam_pkg::PSAM_REG_HOLE;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/psam_top.sv
`timescale 1ns/10ps
`default_nettype none

module psam_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  // Page register loads from the core
  input  wire logic        table_page_load,
  input  wire logic [7:0]  table_page_value,
  input  wire logic        remap_page_load,
  input  wire logic [7:0]  remap_page_value,
  output logic [7:0]       table_page_register,
  output logic [7:0]       remap_page,
  // Instruction fetch
  input  wire logic        fetch_req,
  input  wire logic [22:0] instruction_pointer,
  output logic             fetch_ready,
  // Table operations
  input  wire logic        table_req,
  input  wire logic        table_write_op,
  input  wire logic        table_high,
  input  wire logic [15:0] table_offset,
  input  wire logic [15:0] table_wdata,
  output logic             table_ready,
  // Data space remap reads
  input  wire logic        remap_req,
  input  wire logic [15:0] data_space_addr,
  output logic             remap_ready,
  // Response to the core
  output logic             rsp_valid,
  output logic [23:0]      rsp_data,
  output logic             rsp_fault,
  output logic [1:0]       rsp_src,
  // Program memory bus
  output logic             pm_valid,
  output logic [23:0]      pm_addr,
  output logic             pm_write,
  output logic [23:0]      pm_wdata,
  output logic [2:0]       pm_wstrb,
  input  wire logic        pm_ready,
  input  wire logic [23:0] pm_rdata
);

  typedef enum logic [1:0] {
    PSAM_IDLE,
    PSAM_CHECK,
    PSAM_BUS,
    PSAM_DONE
  } psam_state_e;

  psam_state_e         state;
  psam_state_e         next_state;
  psam_pkg::psam_src_e cur_src;
  logic [22:0]         cur_ip;
  logic [15:0]         cur_ofs;
  logic [15:0]         cur_ds;
  logic [15:0]         cur_wdata;
  logic                cur_write;
  logic                cur_high;
  logic                grant_table;
  logic                grant_remap;
  logic                grant_fetch;
  logic                allowed;

  psam_if af ();

  psam_addr_gen u_addr_gen (
    .af (af)
  );

  assign af.src        = cur_src;
  assign af.ip         = cur_ip;
  assign af.table_page = table_page_register;
  assign af.table_ofs  = cur_ofs;
  assign af.remap_page = remap_page;
  assign af.ds_addr    = cur_ds;

  // Table work outranks remap, remap outranks fetch
  assign grant_table = (state == PSAM_IDLE) && table_req;
  assign grant_remap = (state == PSAM_IDLE) && !table_req && remap_req &&
                       data_space_addr[psam_pkg::DS_REMAP_BIT];
  assign grant_fetch = (state == PSAM_IDLE) && !table_req && !remap_req &&
                       fetch_req;
  assign table_ready = grant_table;
  assign remap_ready = (state == PSAM_IDLE) && !table_req && remap_req;
  assign fetch_ready = grant_fetch;

  // Gate: upper half only for table ops through page bit 7
  always_comb begin
    if (!af.upper) begin
      allowed = (af.region == psam_pkg::PSAM_REG_USER);
    end else if (cur_src != psam_pkg::PSAM_SRC_TABLE) begin
      allowed = 1'b0;
    end else if (!table_page_register[psam_pkg::PAGE_UPPER_BIT]) begin
      allowed = 1'b0;
    end else if (af.region == psam_pkg::PSAM_REG_CONFIG) begin
      allowed = 1'b1;
    end else if (af.region == psam_pkg::PSAM_REG_DEVID) begin
      // Identification words are read only
      allowed = !cur_write;
    end else begin
      allowed = 1'b0;
    end
  end

  always_comb begin
    case (state)
      PSAM_IDLE: begin
        if (grant_table || grant_remap || grant_fetch) begin
          next_state = PSAM_CHECK;
        end else if (remap_ready) begin
          // Remap outside the window is answered with a fault
          next_state = PSAM_DONE;
        end else begin
          next_state = PSAM_IDLE;
        end
      end
      PSAM_CHECK: begin
        next_state = allowed ? PSAM_BUS : PSAM_DONE;
      end
      PSAM_BUS: begin
        next_state = pm_ready ? PSAM_DONE : PSAM_BUS;
      end
      PSAM_DONE: begin
        next_state = PSAM_IDLE;
      end
      default: begin
        next_state = PSAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= PSAM_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Page registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      table_page_register <= psam_pkg::TABLE_PAGE_RST;
      remap_page          <= psam_pkg::REMAP_PAGE_RST;
    end else begin
      if (table_page_load) begin
        table_page_register <= table_page_value;
      end
      if (remap_page_load) begin
        remap_page <= remap_page_value;
      end
    end
  end

  // Capture of the granted request
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur_src   <= psam_pkg::PSAM_SRC_FETCH;
      cur_ip    <= '0;
      cur_ofs   <= '0;
      cur_ds    <= '0;
      cur_wdata <= '0;
      cur_write <= 1'b0;
      cur_high  <= 1'b0;
    end else if (state == PSAM_IDLE) begin
      if (grant_table) begin
        cur_src   <= psam_pkg::PSAM_SRC_TABLE;
        cur_ofs   <= table_offset;
        cur_wdata <= table_wdata;
        cur_write <= table_write_op;
        cur_high  <= table_high;
      end else if (remap_ready) begin
        cur_src   <= psam_pkg::PSAM_SRC_REMAP;
        cur_ds    <= data_space_addr;
        cur_write <= 1'b0;
        cur_high  <= 1'b0;
      end else if (grant_fetch) begin
        cur_src   <= psam_pkg::PSAM_SRC_FETCH;
        cur_ip    <= instruction_pointer;
        cur_write <= 1'b0;
        cur_high  <= 1'b0;
      end
    end
  end

  // Program memory bus, driven only for allowed accesses
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pm_valid <= 1'b0;
      pm_addr  <= psam_pkg::USER_FIRST;
      pm_write <= 1'b0;
      pm_wdata <= '0;
      pm_wstrb <= psam_pkg::STRB_NONE;
    end else if (state == PSAM_CHECK && allowed) begin
      pm_valid <= 1'b1;
      pm_addr  <= af.paddr;
      pm_write <= cur_write;
      if (!cur_write) begin
        pm_wdata <= '0;
        pm_wstrb <= psam_pkg::STRB_NONE;
      end else if (cur_high) begin
        pm_wdata <= {cur_wdata[7:0], 16'h0000};
        pm_wstrb <= psam_pkg::STRB_HIGH;
      end else begin
        pm_wdata <= {8'h00, cur_wdata};
        pm_wstrb <= psam_pkg::STRB_LOW;
      end
    end else if (state == PSAM_BUS && pm_ready) begin
      pm_valid <= 1'b0;
      pm_write <= 1'b0;
      pm_wstrb <= psam_pkg::STRB_NONE;
    end
  end

  // Response: a one-cycle pulse with the word, its low 16 bits or its upper byte; zero data for writes and faults
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
      rsp_fault <= 1'b0;
      rsp_src   <= 2'h0;
    end else begin
      rsp_valid <= 1'b0;
      if ((state == PSAM_CHECK && !allowed) ||
          (state == PSAM_IDLE && remap_ready && !grant_remap)) begin
        rsp_valid <= 1'b1;
        rsp_data  <= '0;
        rsp_fault <= 1'b1;
        rsp_src   <= (state == PSAM_IDLE) ? 2'(psam_pkg::PSAM_SRC_REMAP)
                                          : 2'(cur_src);
      end else if (state == PSAM_BUS && pm_ready) begin
        rsp_valid <= 1'b1;
        rsp_fault <= 1'b0;
        rsp_src   <= 2'(cur_src);
        if (cur_write) begin
          rsp_data <= '0;
        end else if (cur_src == psam_pkg::PSAM_SRC_FETCH) begin
          rsp_data <= pm_rdata;
        end else if (cur_high) begin
          rsp_data <= {16'h0000, pm_rdata[23:16]};
        end else begin
          rsp_data <= {8'h00, pm_rdata[15:0]};
        end
      end
    end
  end

endmodule

`default_nettype wire

// >>> dv/psam_chk.sv
`timescale 1ns/10ps
`default_nettype none

module psam_chk (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset,
  // Core side
  input wire logic [7:0]  table_page_register,
  input wire logic [7:0]  remap_page,
  input wire logic        fetch_req,
  input wire logic [22:0] instruction_pointer,
  input wire logic        fetch_ready,
  input wire logic        table_req,
  input wire logic        table_ready,
  input wire logic        remap_req,
  input wire logic [15:0] data_space_addr,
  input wire logic        remap_ready,
  input wire logic        rsp_valid,
  input wire logic        rsp_fault,
  input wire logic [1:0]  rsp_src,
  // Memory side
  input wire logic        pm_valid,
  input wire logic [23:0] pm_addr,
  input wire logic        pm_ready
);
  logic [14:0] ds_low;
  assign ds_low = data_space_addr[14:0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  fetch_addr_a: assert property (fetch_req && fetch_ready |-> ##2
    pm_valid && pm_addr == {1'b0, $past(instruction_pointer, 2)})
    else $error("fetch address wrong");
  table_page_a: assert property (table_req && table_ready |-> ##2
    !pm_valid || pm_addr[23:16] == $past(table_page_register))
    else $error("table page not used");
  remap_addr_a: assert property (remap_req && remap_ready &&
    data_space_addr[15] |-> ##2 pm_valid &&
    pm_addr == {1'b0, $past(remap_page), $past(ds_low, 2)})
    else $error("remap address wrong");
  remap_fault_a: assert property (remap_req && remap_ready &&
    !data_space_addr[15] |=> rsp_valid && rsp_fault && rsp_src == 2'h2)
    else $error("remap outside window not refused");
  upper_map_a: assert property (pm_valid && pm_addr[23] |->
    pm_addr[23:8] == 16'hF800 || pm_addr[23:2] == 22'h3FC000)
    else $error("upper half access outside config or id");
  hold_bus_a: assert property (pm_valid && !pm_ready |=>
    pm_valid && $stable(pm_addr))
    else $error("memory request dropped");
  ok_rsp_a: assert property (pm_valid && pm_ready |=>
    rsp_valid && !rsp_fault)
    else $error("no clean response after memory");
  fault_quiet_a: assert property (rsp_valid && rsp_fault |->
    !pm_valid)
    else $error("blocked access reached memory");
  cover property (table_req && table_ready && table_page_register[7]);
  cover property (pm_valid && !pm_ready);
  cover property (rsp_valid && rsp_fault);
endmodule

bind psam_top psam_chk chk_u (.*);

`default_nettype wire

// >>> dv/psam_pm_model.sv
`timescale 1ns/10ps
`default_nettype none

module psam_pm_model (
  // Clock and stall length
  input  wire logic        core_clk,
  input  wire logic [3:0]  wait_cycles,
  // Program memory bus
  input  wire logic        pm_valid,
  input  wire logic [23:0] pm_addr,
  input  wire logic        pm_write,
  input  wire logic [23:0] pm_wdata,
  input  wire logic [2:0]  pm_wstrb,
  output logic             pm_ready,
  output logic [23:0]      pm_rdata,
  // Last write taken
  output logic [23:0]      wr_data,
  output logic [2:0]       wr_strb
);
  logic [3:0] stall;
  logic       toggle = 1'b0;
  always_ff @(posedge core_clk) begin
    stall  <= (pm_valid && !pm_ready) ? stall + 4'h1 : 4'h0;
    toggle <= !toggle;
    if (pm_ready && pm_write) begin
      wr_data <= pm_wdata;
      wr_strb <= pm_wstrb;
    end
  end
  assign pm_ready = pm_valid && (stall >= wait_cycles);
  // Word per 24-bit address; junk when not answering
  assign pm_rdata = pm_ready ? pm_addr ^ 24'hA5C33C : {24{toggle}};
endmodule

`default_nettype wire

// >>> dv/tb_program_space_access_map.sv
`timescale 1ns/10ps
`default_nettype none

module tb_program_space_access_map;
  typedef struct packed {
    logic [1:0]  kind;
    logic [7:0]  page;
    logic [22:0] a;
    logic        high;
    logic [3:0]  dly;
    logic        flt;
  } psam_row_s;
  logic        core_clk, reset, fetch_req, table_req, remap_req;
  logic        table_page_load, remap_page_load, table_write_op, table_high;
  logic        fetch_ready, table_ready, remap_ready, pm_ready;
  logic        rsp_valid, rsp_fault, pm_valid, pm_write;
  logic [1:0]  rsp_src;
  logic [2:0]  pm_wstrb, wr_strb;
  logic [3:0]  wait_cycles;
  logic [7:0]  table_page_value, remap_page_value;
  logic [7:0]  table_page_register, remap_page;
  logic [15:0] table_offset, table_wdata, data_space_addr;
  logic [22:0] instruction_pointer;
  logic [23:0] rsp_data, pm_addr, pm_wdata, pm_rdata, wr_data;
  int          bad_count, comparisons;
  // Kind: 0 fetch, 1 table read, 2 remap, 3 table write
  psam_row_s rows [11] = '{
    '{2'h0, 8'h00, 23'h7FFFFF, 1'b0, 4'h0, 1'b0},
    '{2'h1, 8'h00, 23'h000010, 1'b0, 4'h2, 1'b0},
    '{2'h1, 8'h80, 23'h000010, 1'b0, 4'h0, 1'b1},
    '{2'h1, 8'hF8, 23'h000005, 1'b1, 4'h1, 1'b0},
    '{2'h1, 8'hFF, 23'h000002, 1'b0, 4'h0, 1'b0},
    '{2'h3, 8'hFF, 23'h000000, 1'b0, 4'h0, 1'b1},
    '{2'h3, 8'hF8, 23'h0000FF, 1'b1, 4'h3, 1'b0},
    '{2'h1, 8'h7F, 23'h00FFFF, 1'b0, 4'h0, 1'b0},
    '{2'h2, 8'h12, 23'h008123, 1'b0, 4'h1, 1'b0},
    '{2'h2, 8'h12, 23'h000123, 1'b0, 4'h0, 1'b1},
    '{2'h3, 8'h00, 23'h000020, 1'b0, 4'h0, 1'b0}};

  psam_top dut_u (.*);
  psam_pm_model mem_u (.*);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("Compared %0d, mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic await_take;
    int n;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if ((fetch_ready | table_ready | remap_ready) === 1'b1) break;
    end
    if (n == 20) begin
      bad_count++;
      tally_and_finish;
    end
    fetch_req <= fetch_req & ~fetch_ready;
    table_req <= table_req & ~table_ready;
    remap_req <= remap_req & ~remap_ready;
    {table_page_load, remap_page_load} <= 2'h0;
  endtask

  task automatic await_rsp(output logic [23:0] seen);
    int n;
    seen = 24'h0;
    for (n = 0; n < 40 && rsp_valid !== 1'b1; n++) begin
      @(posedge core_clk);
      if ((pm_valid & pm_ready) === 1'b1) seen = pm_addr;
    end
    if (rsp_valid !== 1'b1) begin
      bad_count++;
      tally_and_finish;
    end
  endtask

  initial begin
    psam_row_s   r;
    logic [23:0] seen, w, m, ed;
    {reset, fetch_req, table_req, remap_req} = 4'h8;
    {table_page_load, remap_page_load, table_write_op, table_high} = 4'h0;
    {table_page_value, remap_page_value, wait_cycles} = 20'h0;
    {table_offset, data_space_addr, instruction_pointer} = 55'h0;
    table_wdata = 16'h12AB;
    bad_count = 0;
    comparisons = 0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    check({6'h0, pm_valid, rsp_valid, table_page_register, remap_page},
          24'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      r = rows[i];
      wait_cycles <= r.dly;
      {table_page_value, remap_page_value} <= {r.page, r.page};
      table_page_load <= r.kind[0];
      remap_page_load <= r.kind == 2'h2;
      fetch_req <= r.kind == 2'h0;
      table_req <= r.kind[0];
      remap_req <= r.kind == 2'h2;
      table_write_op <= r.kind == 2'h3;
      table_high <= r.high;
      instruction_pointer <= r.a;
      table_offset <= r.a[15:0];
      data_space_addr <= r.a[15:0];
      await_take;
      await_rsp(seen);
      w = (r.kind == 2'h0) ? {1'b0, r.a} : (r.kind == 2'h2) ?
          {1'b0, r.page, r.a[14:0]} : {r.page, r.a[15:0]};
      m = w ^ 24'hA5C33C;
      if (r.flt || r.kind == 2'h3) ed = 24'h0;
      else if (r.kind == 2'h0) ed = m;
      else if (r.high) ed = {16'h0, m[23:16]};
      else ed = {8'h0, m[15:0]};
      check({23'h0, rsp_fault}, {23'h0, r.flt});
      check({22'h0, rsp_src}, {22'h0, r.kind == 2'h3 ? 2'h1 : r.kind});
      check(rsp_data, ed);
      check(seen, r.flt ? 24'h0 : w);
      if (r.kind == 2'h3 && !r.flt) begin
        check(wr_data, r.high ? 24'hAB0000 : 24'h0012AB);
        check({21'h0, wr_strb}, r.high ? 24'h4 : 24'h3);
      end
      $display("row %0d done", i);
    end
    // Table and fetch raised together; table goes first
    {table_write_op, table_high} <= 2'h0;
    table_offset <= 16'h0040;
    instruction_pointer <= 23'h000040;
    {fetch_req, table_req} <= 2'h3;
    await_take;
    check({23'h0, fetch_ready}, 24'h0);
    await_rsp(seen);
    check({22'h0, rsp_src}, 24'h1);
    check(seen, 24'h000040);
    await_take;
    await_rsp(seen);
    check({22'h0, rsp_src}, 24'h0);
    check(rsp_data, 24'h000040 ^ 24'hA5C33C);
    $display("priority test done");
    // Load a nonzero page so that the reset has something to clear
    table_page_value <= 8'h5A;
    table_page_load <= 1'b1;
    @(posedge core_clk);
    table_page_load <= 1'b0;
    reset <= 1'b1;
    @(posedge core_clk);
    check({16'h0, table_page_register}, 24'h00005A);
    @(posedge core_clk);
    check({8'h0, table_page_register, remap_page}, 24'h0);
    // Fetch raised for the first edge after release
    reset <= 1'b0;
    instruction_pointer <= 23'h000123;
    fetch_req <= 1'b1;
    await_take;
    await_rsp(seen);
    check({22'h0, rsp_src}, 24'h0);
    check({23'h0, rsp_fault}, 24'h0);
    check(rsp_data, 24'h000123 ^ 24'hA5C33C);
    check(seen, 24'h000123);
    $display("mid-run reset test done");
    tally_and_finish;
  end
endmodule

`default_nettype wire
